// >>> adc_channel_sequencer.sv
// adc_channel_sequencer: mode control, channel selection, result store.
// assumes the analog mux, dividers and comparator run on i_clock.
`timescale 1ns/10ps
`default_nettype none
module adc_channel_sequencer
    import adc_seq_pkg::*;
#(
    parameter int WIDTH = 10
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [1:0] i_mode,
    input wire logic [5:0] i_channel,
    input wire logic [7:0] i_enable_cycles,
    input wire logic [7:0] i_sample_cycles,
    input wire logic i_comparator,
    input wire logic [4:0] i_read_channel,
    output logic [4:0] o_mux_select,
    output logic [4:0] o_divider_ratio,
    output logic o_diff_sense,
    output logic o_adc_enable,
    output logic o_sample_hold,
    output logic [WIDTH-1:0] o_sar_trial,
    output logic o_busy,
    output logic o_interrupt,
    output logic o_new_result,
    output logic o_auto_member,
    output logic [4:0] o_last_channel,
    output logic [WIDTH-1:0] o_last_code,
    output logic [WIDTH-1:0] o_read_data
);
    state_type state_q;
    mode_type mode_q;
    logic [4:0] chan_q;
    logic [7:0] timer_q;
    logic stop_q;
    logic [WIDTH-1:0] result_q [32];
    logic [WIDTH-1:0] read_q;
    logic [4:0] last_chan_q;
    logic [WIDTH-1:0] last_code_q;
    logic new_q;
    logic req_mapped;
    logic req_auto;
    logic start_ok;
    logic chan_is_last;
    logic [7:0] enable_load;
    logic [7:0] sample_load;

    sar_if #(.WIDTH(WIDTH)) sar();

    sar_engine #(.WIDTH(WIDTH)) u_sar (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .sar(sar.engine)
    );

    // ------------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------------
    assign req_mapped = i_channel < NUM_CHANNELS;
    assign req_auto = i_mode[1];
    assign start_ok = i_start && (state_q == S_IDLE)
        && (req_auto || req_mapped);
    assign chan_is_last = chan_q == AUTO_LAST;
    // a zero count still spends one cycle, so the sequence never skips
    assign enable_load = (i_enable_cycles == 8'h00) ? 8'h00
        : i_enable_cycles - 8'h01;
    assign sample_load = (i_sample_cycles == 8'h00) ? 8'h00
        : i_sample_cycles - 8'h01;

    assign sar.start = (state_q == S_SAMPLE) && (timer_q == 8'h00);
    assign sar.comp = i_comparator;

    // ------------------------------------------------------------------
    // sequencing state machine
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            state_q <= S_IDLE;
            mode_q <= MODE_SINGLE;
            chan_q <= AUTO_FIRST;
            timer_q <= TIMER_RESET;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (start_ok) begin
                        mode_q <= mode_type'(i_mode);
                        chan_q <= req_auto ? AUTO_FIRST
                            : i_channel[4:0];
                        timer_q <= enable_load;
                        state_q <= S_ENABLE;
                    end
                end
                S_ENABLE: begin
                    if (timer_q == 8'h00) begin
                        timer_q <= sample_load;
                        state_q <= S_SAMPLE;
                    end else begin
                        timer_q <= timer_q - 8'h01;
                    end
                end
                S_SAMPLE: begin
                    if (timer_q == 8'h00) begin
                        state_q <= S_CONVERT;
                    end else begin
                        timer_q <= timer_q - 8'h01;
                    end
                end
                S_CONVERT: begin
                    if (sar.done) begin
                        case (mode_q)
                            MODE_ROUND_ROBIN: begin
                                chan_q <= chan_is_last ? AUTO_FIRST
                                    : chan_q + 5'h01;
                                timer_q <= sample_load;
                                state_q <= (stop_q && chan_is_last)
                                    ? S_IDLE : S_SAMPLE;
                            end
                            MODE_ONE_TIME_AUTO: begin
                                if (chan_is_last) begin
                                    timer_q <= INTERRUPT_PULSE_TIME - 8'h01;
                                    state_q <= S_INTR;
                                end else begin
                                    chan_q <= chan_q + 5'h01;
                                    timer_q <= sample_load;
                                    state_q <= S_SAMPLE;
                                end
                            end
                            default: begin
                                timer_q <= INTERRUPT_PULSE_TIME - 8'h01;
                                state_q <= S_INTR;
                            end
                        endcase
                    end
                end
                S_INTR: begin
                    if (timer_q != 8'h00) begin
                        timer_q <= timer_q - 8'h01;
                    end else if (mode_q == MODE_SINGLE_REPEAT && !stop_q) begin
                        timer_q <= sample_load;
                        state_q <= S_SAMPLE;
                    end else begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // stop is only honoured at a safe boundary, never mid-conversion
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            stop_q <= 1'b0;
        end else if (state_q == S_IDLE) begin
            stop_q <= 1'b0;
        end else if (i_stop) begin
            stop_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // result store
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < 32; i++) begin
                result_q[i] <= RESULT_RESET;
            end
        end else if (sar.done) begin
            result_q[chan_q] <= sar.code;
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            read_q <= RESULT_RESET;
            last_chan_q <= AUTO_FIRST;
            last_code_q <= RESULT_RESET;
            new_q <= 1'b0;
        end else begin
            read_q <= result_q[i_read_channel];
            new_q <= sar.done;
            if (sar.done) begin
                last_chan_q <= chan_q;
                last_code_q <= sar.code;
            end
        end
    end

    // ------------------------------------------------------------------
    // analog front-end controls, status and result outputs
    // ------------------------------------------------------------------
    assign o_mux_select = chan_q;
    assign o_divider_ratio = divider_of(chan_q);
    assign o_diff_sense = chan_q == CH_EXTERNAL_PATH_CURRENT;
    assign o_auto_member = chan_q <= AUTO_LAST;
    assign o_adc_enable = state_q != S_IDLE;
    assign o_sample_hold = state_q == S_SAMPLE;
    assign o_sar_trial = sar.trial;
    assign o_busy = state_q != S_IDLE;
    assign o_interrupt = state_q == S_INTR;
    assign o_new_result = new_q;
    assign o_last_channel = last_chan_q;
    assign o_last_code = last_code_q;
    assign o_read_data = read_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_int_two;
        @(posedge i_clock) disable iff (i_reset)
        $rose(o_interrupt) |-> o_interrupt [*2] ##1 !o_interrupt;
    endproperty
    a_int_two: assert property (p_int_two)
        else $error("interrupt not held for two cycles");

    property p_auto_range;
        @(posedge i_clock) disable iff (i_reset)
        (o_busy && mode_q[1]) |-> o_mux_select <= AUTO_LAST;
    endproperty
    a_auto_range: assert property (p_auto_range)
        else $error("auto sequence left channels 0 to 10");

    property p_unmapped;
        @(posedge i_clock) disable iff (i_reset)
        (i_start && state_q == S_IDLE && !i_mode[1] && !req_mapped)
            |=> state_q == S_IDLE && $stable(mode_q);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped channel request was acted on");

    property p_store;
        @(posedge i_clock) disable iff (i_reset)
        sar.done |=> result_q[$past(chan_q)] == $past(sar.code);
    endproperty
    a_store: assert property (p_store)
        else $error("result not stored for its channel");

    property p_rr_wrap;
        @(posedge i_clock) disable iff (i_reset)
        (sar.done && mode_q == MODE_ROUND_ROBIN && chan_is_last && !stop_q)
            |=> chan_q == AUTO_FIRST && state_q == S_SAMPLE;
    endproperty
    a_rr_wrap: assert property (p_rr_wrap)
        else $error("round robin did not wrap to channel 0");

    property p_one_time_end;
        @(posedge i_clock) disable iff (i_reset)
        (sar.done && mode_q == MODE_ONE_TIME_AUTO && chan_is_last)
            |=> o_interrupt ##2 state_q == S_IDLE;
    endproperty
    a_one_time_end: assert property (p_one_time_end)
        else $error("one-time sequence did not end with interrupt");

    property p_single_stop;
        @(posedge i_clock) disable iff (i_reset)
        (sar.done && mode_q == MODE_SINGLE) |=> o_interrupt ##2 !o_busy;
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("single conversion did not stop");

    property p_divider;
        @(posedge i_clock) disable iff (i_reset)
        (o_mux_select == CH_EXT_SENSE_HIGH) |-> o_divider_ratio == 5'h19
            && !o_diff_sense;
    endproperty
    a_divider: assert property (p_divider)
        else $error("wrong divider on sense-high channel");

    c_single: cover property (@(posedge i_clock) disable iff (i_reset)
        sar.done && mode_q == MODE_SINGLE);
    c_rr_wrap: cover property (@(posedge i_clock) disable iff (i_reset)
        sar.done && mode_q == MODE_ROUND_ROBIN && chan_is_last);
    c_one_time: cover property (@(posedge i_clock) disable iff (i_reset)
        $rose(o_interrupt) && mode_q == MODE_ONE_TIME_AUTO);
endmodule
`default_nettype wire

// >>> adc_front_model.sv
// adc_front_model: analog mux, sample-hold and comparator seen by the sequencer.
// assumes one clock; levels are synthetic, made from channel and a bias input.
`timescale 1ns/10ps
`default_nettype none
module adc_front_model (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [4:0] i_mux_select,
    input wire logic i_diff_sense,
    input wire logic i_adc_enable,
    input wire logic i_sample_hold,
    input wire logic [9:0] i_sar_trial,
    input wire logic [9:0] i_bias,
    output logic o_comparator
);
    // ------------------------------------------------------------------
    // input level and comparator
    // ------------------------------------------------------------------
    logic [9:0] live;
    logic [9:0] held_q;
    logic toggle_q;

    // sense-high sits 10'h064 above sense-low: only the difference is right
    always_comb begin
        live = 10'(i_mux_select) * 10'h01d + i_bias;
        if (i_mux_select == 5'h03 && !i_diff_sense) begin
            live = live + 10'h064;
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            held_q <= 10'h000;
            toggle_q <= 1'b0;
        end else begin
            toggle_q <= !toggle_q;
            if (i_sample_hold) begin
                held_q <= live;
            end
        end
    end

    // a disabled front end gives no steady answer, so it wanders
    assign o_comparator = !i_adc_enable ? toggle_q :
        ((i_sample_hold ? live : held_q) >= i_sar_trial);
endmodule
`default_nettype wire

// >>> adc_seq_pkg.sv
// adc_seq_pkg: constants, modes and channel map for the adc sequencer.
// assumes one 40 MHz core clock shared by the sequencer and the converter.
package adc_seq_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 25;
    localparam logic [3:0] CONVERT_CYCLES = 4'hc;
    localparam logic [7:0] INTERRUPT_PULSE_TIME = 8'h02;

    // ------------------------------------------------------------------
    // channel map
    // ------------------------------------------------------------------
    localparam logic [5:0] NUM_CHANNELS = 6'h20;
    localparam logic [4:0] AUTO_FIRST = 5'h00;
    localparam logic [4:0] AUTO_LAST = 5'h0a;
    localparam logic [4:0] CH_THERMAL = 5'h00;
    localparam logic [4:0] CH_EXT_SENSE_HIGH = 5'h02;
    localparam logic [4:0] CH_EXTERNAL_PATH_CURRENT = 5'h03;
    localparam logic [4:0] CH_CC1_DIV5 = 5'h08;
    localparam logic [4:0] CH_CC2_DIV5 = 5'h0a;
    localparam logic [4:0] CH_CC1_DIV2 = 5'h0c;
    localparam logic [4:0] CH_CC2_DIV2 = 5'h0d;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam logic [7:0] TIMER_RESET = 8'h00;

    // ------------------------------------------------------------------
    // modes and states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_SINGLE_REPEAT = 2'h1,
        MODE_ROUND_ROBIN = 2'h2,
        MODE_ONE_TIME_AUTO = 2'h3
    } mode_type;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_ENABLE = 5'h02,
        S_SAMPLE = 5'h04,
        S_CONVERT = 5'h08,
        S_INTR = 5'h10
    } state_type;

    // fixed front-end divider per channel; 0 means no divider
    function automatic logic [4:0] divider_of(input logic [4:0] ch);
        logic [4:0] r;
        r = 5'h00;
        case (ch)
            5'h01, 5'h02, 5'h04: r = 5'h19;
            5'h06, 5'h08, 5'h0a, 5'h0e: r = 5'h05;
            5'h0b: r = 5'h01;
            5'h0c, 5'h0d, 5'h12, 5'h13: r = 5'h02;
            5'h00, 5'h03, 5'h05, 5'h07, 5'h09: r = 5'h00;
            default: r = 5'h03;
        endcase
        return r;
    endfunction

endpackage

// >>> sar_engine.sv
// sar_engine: successive approximation over twelve clock cycles.
// assumes the comparator answers the trial word within one cycle.
`timescale 1ns/10ps
`default_nettype none
module sar_engine
    import adc_seq_pkg::*;
#(
    parameter int WIDTH = 10
) (
    input wire logic i_clock,
    input wire logic i_reset,
    sar_if.engine sar
);
    logic [3:0] cnt_q;
    logic busy_q;
    logic [WIDTH-1:0] trial_q;
    logic [WIDTH-1:0] trial_d;

    // ------------------------------------------------------------------
    // bit decisions
    // ------------------------------------------------------------------
    always_comb begin
        int b;
        b = WIDTH - int'(cnt_q);
        trial_d = trial_q;
        if (busy_q && cnt_q != 4'h0 && b >= 0) begin
            if (!sar.comp) begin
                trial_d[b] = 1'b0;
            end
            if (b > 0) begin
                trial_d[b-1] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            trial_q <= '0;
        end else if (sar.start && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q <= 4'h0;
            trial_q <= {1'b1, {(WIDTH-1){1'b0}}};
        end else if (busy_q) begin
            trial_q <= trial_d;
            if (cnt_q == CONVERT_CYCLES - 4'h1) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    assign sar.busy = busy_q;
    assign sar.done = busy_q && (cnt_q == CONVERT_CYCLES - 4'h1);
    assign sar.trial = trial_q;
    assign sar.code = trial_q;

    property p_done_after_twelve;
        @(posedge i_clock) disable iff (i_reset)
        (sar.start && !busy_q)
            |-> !sar.done [*8] ##1 !sar.done [*4] ##1 sar.done;
    endproperty
    a_done_after_twelve: assert property (p_done_after_twelve)
        else $error("conversion did not finish in twelve cycles");
endmodule
`default_nettype wire

// >>> sar_if.sv
// sar_if: handshake between sequencer control and the sar engine.
// assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface sar_if #(parameter int WIDTH = 10);
    logic start;
    logic comp;
    logic busy;
    logic done;
    logic [WIDTH-1:0] trial;
    logic [WIDTH-1:0] code;
    modport engine(input start, input comp, output busy, output done,
        output trial, output code);
    modport ctrl(output start, output comp, input busy, input done,
        input trial, input code);
endinterface
`default_nettype wire

// >>> tb.sv
// tb: self-checking bench for the adc channel sequencer.
// assumes the front-end model answers the comparator within one cycle.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic i_clock, i_reset, i_start, i_stop, i_comparator;
    logic [1:0] i_mode;
    logic [5:0] i_channel;
    logic [7:0] i_enable_cycles, i_sample_cycles;
    logic [4:0] i_read_channel, o_mux_select, o_divider_ratio, o_last_channel;
    logic o_diff_sense, o_adc_enable, o_sample_hold, o_busy;
    logic o_interrupt, o_new_result, o_auto_member;
    logic [9:0] o_sar_trial, o_last_code, o_read_data, bias;
    logic [4:0] exp_ch;
    logic auto_run;
    int bad_count = 0;
    int check_count = 0;
    int results = 0;
    int intr_cycles = 0;
    int n;

    adc_channel_sequencer #(.WIDTH(10)) u_dut (.i_clock, .i_reset, .i_start,
        .i_stop, .i_mode, .i_channel, .i_enable_cycles, .i_sample_cycles,
        .i_comparator, .i_read_channel, .o_mux_select, .o_divider_ratio,
        .o_diff_sense, .o_adc_enable, .o_sample_hold, .o_sar_trial, .o_busy,
        .o_interrupt, .o_new_result, .o_auto_member, .o_last_channel,
        .o_last_code, .o_read_data);

    adc_front_model u_model (.i_clock, .i_reset, .i_mux_select(o_mux_select),
        .i_diff_sense(o_diff_sense), .i_adc_enable(o_adc_enable),
        .i_sample_hold(o_sample_hold), .i_sar_trial(o_sar_trial),
        .i_bias(bias), .o_comparator(i_comparator));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [9:0] lvl(input logic [4:0] ch,
        input logic [9:0] b);
        return 10'(ch) * 10'h01d + b;
    endfunction

    function automatic logic [9:0] div_exp(input logic [4:0] ch);
        case (ch)
            5'h01, 5'h02, 5'h04: return 10'h019;
            5'h06, 5'h08, 5'h0a, 5'h0e: return 10'h005;
            5'h0b: return 10'h001;
            5'h0c, 5'h0d, 5'h12, 5'h13: return 10'h002;
            5'h00, 5'h03, 5'h05, 5'h07, 5'h09: return 10'h000;
            default: return 10'h003;
        endcase
    endfunction

    task automatic check(input logic [9:0] seen, input logic [9:0] expv);
        check_count++;
        if (seen !== expv) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                expv);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // returns just after the edge that takes the request
    task automatic start_run(input logic [1:0] mode, input logic [5:0] ch,
        input logic [7:0] en);
        @(posedge i_clock);
        i_start <= 1'b1;
        i_mode <= mode;
        i_channel <= ch;
        i_enable_cycles <= en;
        @(posedge i_clock);
        i_start <= 1'b0;
    endtask

    task automatic read_back(input logic [4:0] ch, input logic [9:0] expv);
        @(posedge i_clock);
        i_read_channel <= ch;
        @(posedge i_clock);
        #1;
        check(o_read_data, expv);
    endtask

    task automatic wait_idle;
        for (n = 0; n < 900 && o_busy !== 1'b0; n++) @(posedge i_clock);
        i_stop <= 1'b0;
        #1;
        check(10'(o_busy), 10'h000);
    endtask

    // enable time follows the channel's low bits; zero counts as one
    task automatic convert_one(input logic [4:0] ch);
        int cnt;
        int e;
        int held;
        exp_ch = ch;
        e = (ch[1:0] == 2'h0) ? 1 : int'(ch[1:0]);
        start_run(2'h0, {1'b0, ch}, {6'h00, ch[1:0]});
        #1;
        check(10'(o_busy & o_adc_enable), 10'h001);
        cnt = 0;
        held = 0;
        while (o_interrupt !== 1'b1 && cnt < 100) begin
            @(posedge i_clock);
            #1;
            cnt++;
            held += int'(o_sample_hold === 1'b1);
        end
        // enable, two sample cycles, twelve convert cycles
        check(10'(cnt), 10'(e + 14));
        check(10'(held), 10'h002);
        check(o_sar_trial, lvl(ch, bias));
        check(10'(o_new_result), 10'h001);
        check(10'(o_mux_select), 10'(ch));
        check(10'(o_divider_ratio), div_exp(ch));
        check(10'(o_diff_sense), 10'(ch == 5'h03));
        check(10'(o_auto_member), 10'(ch <= 5'h0a));
        @(posedge i_clock);
        #1;
        check(10'(o_interrupt), 10'h001);
        @(posedge i_clock);
        #1;
        check(10'(o_interrupt | o_busy), 10'h000);
    endtask

    // ------------------------------------------------------------------
    // result monitor
    // ------------------------------------------------------------------
    // mid-cycle sampling: registered outputs have settled by then
    always @(negedge i_clock) begin
        if (o_interrupt === 1'b1) begin
            intr_cycles++;
        end
        if (o_new_result === 1'b1) begin
            results++;
            check(10'(o_last_channel), 10'(exp_ch));
            check(o_last_code, lvl(exp_ch, bias));
            if (auto_run) begin
                exp_ch <= (exp_ch == 5'h0a) ? 5'h00 : exp_ch + 5'h01;
            end
        end
    end

    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    initial begin
        repeat (20000) @(posedge i_clock);
        bad_count++;
        print_verdict;
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        i_reset = 1'b1;
        i_start = 1'b0;
        i_stop = 1'b0;
        i_mode = 2'h0;
        i_channel = 6'h00;
        i_enable_cycles = 8'h01;
        i_sample_cycles = 8'h02;
        i_read_channel = 5'h00;
        bias = 10'h007;
        exp_ch = 5'h00;
        auto_run = 1'b0;
        repeat (12) @(posedge i_clock);
        i_reset <= 1'b0;
        @(posedge i_clock);
        #1;
        check(10'(o_busy | o_interrupt | o_new_result), 10'h000);
        check(10'(o_auto_member), 10'h001);
        read_back(5'h1f, 10'h000);
        for (int c = 0; c < 32; c++) begin
            convert_one(5'(c));
            read_back(5'(c), lvl(5'(c), 10'h007));
        end
        // unmapped request: no run, store untouched; the new bias
        // would expose a stray conversion of the truncated channel
        bias = 10'h028;
        start_run(2'h0, 6'h25, 8'h01);
        repeat (3) @(posedge i_clock);
        #1;
        check(10'(o_busy), 10'h000);
        repeat (20) @(posedge i_clock);
        read_back(5'h05, lvl(5'h05, 10'h007));
        // round robin, with a start thrown in that must be ignored
        exp_ch = 5'h00;
        auto_run = 1'b1;
        results = 0;
        intr_cycles = 0;
        start_run(2'h2, 6'h00, 8'h02);
        for (n = 0; n < 900 && results < 5; n++) @(posedge i_clock);
        start_run(2'h0, 6'h14, 8'h01);
        for (n = 0; n < 900 && results < 13; n++) @(posedge i_clock);
        i_stop <= 1'b1;
        wait_idle;
        check(10'(results), 10'h016);
        check(10'(intr_cycles), 10'h000);
        for (int c = 0; c < 12; c++) begin
            read_back(5'(c),
                lvl(5'(c), (c < 11) ? 10'h028 : 10'h007));
        end
        // one-time automatic pass
        bias = 10'h05a;
        exp_ch = 5'h00;
        results = 0;
        intr_cycles = 0;
        start_run(2'h3, 6'h00, 8'h01);
        #1;
        wait_idle;
        check(10'(results), 10'h00b);
        check(10'(intr_cycles), 10'h002);
        // repeated single channel until stopped
        bias = 10'h003;
        auto_run = 1'b0;
        exp_ch = 5'h0c;
        results = 0;
        intr_cycles = 0;
        start_run(2'h1, 6'h0c, 8'h01);
        for (n = 0; n < 900 && results < 2; n++) @(posedge i_clock);
        i_stop <= 1'b1;
        wait_idle;
        check(10'(intr_cycles), 10'(2 * results));
        check(10'(results > 1), 10'h001);
        print_verdict;
    end
endmodule
`default_nettype wire
